// file: hw/swm_pkg.sv
// Package for the masked-write burst SRAM core: widths, lane layout, reset values.
// Assumes one 200 MHz clock; the input and output clock pairs arrive as pins.
package swm_pkg;
   // Word-width configurations
   typedef enum logic [1:0] {
      SWM_W8 = 2'b00,
      SWM_W9 = 2'b01,
      SWM_W18 = 2'b10,
      SWM_W36 = 2'b11
   } swm_cfg_t;
   localparam int SWM_DW = 36;
   localparam int SWM_LANES = 4;
   localparam int SWM_LANE_W = 9;
   localparam int SWM_NIB_W = 4;
   localparam int SWM_AW = 4;
   localparam int SWM_DEPTH = 16;
   localparam int SWM_FIFO_DEPTH = 4;
   localparam int SWM_CMD_W = SWM_AW + 2 * (SWM_DW + SWM_LANES);
   localparam logic [SWM_DW-1:0] SWM_RST_RDATA = 36'h0;
   localparam logic [SWM_LANES-1:0] SWM_RST_MASK = 4'hf;
endpackage

// file: hw/swm_fifo_if.sv
// Carrier between the write capture and the commit FIFO.
// Assumes both ends share the single core clock.
interface swm_fifo_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: hw/swm_fifo.sv
// Small valid/ready FIFO in flip-flops, width and depth as parameters.
// Assumes one clock and an active-low asynchronous reset.
module swm_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Fill and drain sides
   swm_fifo_if.snk s_in,
   swm_fifo_if.src s_out
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0] cnt_r;
   logic push;
   logic pop;

   assign s_in.ready = (cnt_r != (PW+1)'(DEPTH));
   assign s_out.valid = (cnt_r != '0);
   assign s_out.data = mem_r[rp_r];
   assign push = s_in.valid && s_in.ready;
   assign pop = s_out.valid && s_out.ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wp_r] <= s_in.data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   a_fifo_no_over: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cnt_r <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// file: hw/swm_core.sv
// Burst-of-two SRAM core with lane-masked writes and a read port.
// Assumes clock pairs arrive as asynchronous pins, sampled by two flops each, with a third flop for edge detect.
// ==========================================
module swm_core
   import swm_pkg::*;
#(
   parameter swm_pkg::swm_cfg_t CFG = swm_pkg::SWM_W18
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Clock pair pins
   input wire logic i_k,
   input wire logic i_k_n,
   input wire logic i_c,
   input wire logic i_c_n,
   // Control and address pins
   input wire logic i_write_port_select_n,
   input wire logic i_read_port_select_n,
   input wire logic [swm_pkg::SWM_AW-1:0] i_addr,
   // Write data and lane masks
   input wire logic [swm_pkg::SWM_DW-1:0] i_d,
   input wire logic [swm_pkg::SWM_LANES-1:0] i_lane_write_mask_n,
   // Read data
   output logic [swm_pkg::SWM_DW-1:0] o_q,
   output logic [swm_pkg::SWM_DW-1:0] o_q_oe,
   // Back-pressure status
   output logic o_wr_stall
);
   import swm_pkg::*;

   // ==========================================
   // Pin synchronisers and edge detect
   logic [3:0] clk_s1_r;
   logic [3:0] clk_s2_r;
   logic [3:0] clk_s3_r;
   logic [3:0] rise;
   logic [SWM_AW-1:0] addr_s1_r, addr_s2_r;
   logic [SWM_DW-1:0] d_s1_r, d_s2_r;
   logic [SWM_LANES-1:0] m_s1_r, m_s2_r;
   logic [1:0] ps_s1_r, ps_s2_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         clk_s1_r <= 4'hf;
         clk_s2_r <= 4'hf;
         clk_s3_r <= 4'hf;
         addr_s1_r <= '0;
         addr_s2_r <= '0;
         d_s1_r <= '0;
         d_s2_r <= '0;
         m_s1_r <= SWM_RST_MASK;
         m_s2_r <= SWM_RST_MASK;
         ps_s1_r <= 2'h3;
         ps_s2_r <= 2'h3;
      end else begin
         clk_s1_r <= {i_c_n, i_c, i_k_n, i_k};
         clk_s2_r <= clk_s1_r;
         clk_s3_r <= clk_s2_r;
         addr_s1_r <= i_addr;
         addr_s2_r <= addr_s1_r;
         d_s1_r <= i_d;
         d_s2_r <= d_s1_r;
         m_s1_r <= i_lane_write_mask_n;
         m_s2_r <= m_s1_r;
         ps_s1_r <= {i_read_port_select_n, i_write_port_select_n};
         ps_s2_r <= ps_s1_r;
      end
   end
   assign rise = clk_s2_r & ~clk_s3_r;

   // Single-clock strap caught once the synchroniser holds the pins
   logic [1:0] strap_cnt_r;
   logic single_clk_r;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         strap_cnt_r <= 2'h0;
         single_clk_r <= 1'b0;
      end else if (strap_cnt_r != 2'h3) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         // Synchroniser reset value is not the pin: wait two edges
         if (strap_cnt_r == 2'h2) begin
            single_clk_r <= clk_s2_r[2] & clk_s2_r[3];
         end
      end
   end

   // ==========================================
   // Lane mask expansion per configuration
   function automatic logic [SWM_DW-1:0] lane_en(input logic [SWM_LANES-1:0] m_n);
      logic [SWM_DW-1:0] e;
      e = '0;
      case (CFG)
         SWM_W8: begin
            e[3:0] = {SWM_NIB_W{~m_n[0]}};
            e[7:4] = {SWM_NIB_W{~m_n[1]}};
         end
         SWM_W9: e[8:0] = {SWM_LANE_W{~m_n[0]}};
         SWM_W18: begin
            e[8:0] = {SWM_LANE_W{~m_n[0]}};
            e[17:9] = {SWM_LANE_W{~m_n[1]}};
         end
         default: begin
            for (int i = 0; i < SWM_LANES; i++) begin
               e[i*SWM_LANE_W +: SWM_LANE_W] = {SWM_LANE_W{~m_n[i]}};
            end
         end
      endcase
      return e;
   endfunction

   // ==========================================
   // Write capture: first word on K, second plus address on Kn
   typedef enum logic [0:0] {
      SWM_WR_IDLE = 1'b0,
      SWM_WR_SECOND = 1'b1
   } swm_wr_t;
   swm_wr_t wr_st_r;
   logic [SWM_DW-1:0] w0_d_r;
   logic [SWM_LANES-1:0] w0_m_r;
   logic cmd_v_r;
   logic [SWM_CMD_W-1:0] cmd_r;
   swm_fifo_if #(.W(SWM_CMD_W)) f_in ();
   swm_fifo_if #(.W(SWM_CMD_W)) f_out ();

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_st_r <= SWM_WR_IDLE;
         w0_d_r <= '0;
         w0_m_r <= SWM_RST_MASK;
         cmd_v_r <= 1'b0;
         cmd_r <= '0;
      end else begin
         if (cmd_v_r && f_in.ready) begin
            cmd_v_r <= 1'b0;
         end
         case (wr_st_r)
            SWM_WR_IDLE: begin
               if (rise[0] && !ps_s2_r[0]) begin
                  w0_d_r <= d_s2_r;
                  w0_m_r <= m_s2_r;
                  wr_st_r <= SWM_WR_SECOND;
               end
            end
            SWM_WR_SECOND: begin
               if (rise[1]) begin
                  cmd_r <= {addr_s2_r, m_s2_r, d_s2_r, w0_m_r, w0_d_r};
                  cmd_v_r <= 1'b1;
                  wr_st_r <= SWM_WR_IDLE;
               end
            end
            default: wr_st_r <= SWM_WR_IDLE;
         endcase
      end
   end
   assign f_in.valid = cmd_v_r;
   assign f_in.data = cmd_r;

   swm_fifo #(.W(SWM_CMD_W), .DEPTH(SWM_FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .s_in(f_in),
      .s_out(f_out)
   );

   // ==========================================
   // Commit both masked words in one array write
   logic [SWM_DW-1:0] mem_r [SWM_DEPTH];
   logic [SWM_AW-1:0] c_addr;
   logic [SWM_AW-1:0] c_addr1;
   logic [SWM_DW-1:0] c_d0, c_d1, c_e0, c_e1;
   logic [SWM_DW-1:0] wr_span;
   assign {c_addr, c_e1, c_d1, c_e0, c_d0} = {f_out.data[SWM_CMD_W-1 -: SWM_AW],
      lane_en(f_out.data[2*SWM_DW+SWM_LANES +: SWM_LANES]),
      f_out.data[SWM_DW+SWM_LANES +: SWM_DW],
      lane_en(f_out.data[SWM_DW +: SWM_LANES]),
      f_out.data[SWM_DW-1:0]};
   assign c_addr1 = c_addr + 1'b1;
   // Bits that this width stores
   assign wr_span = lane_en('0);
   // Drain pauses in the cycle a read address is taken on K, so the FIFO can back up
   assign f_out.ready = !rise[0] || ps_s2_r[1];

   always_ff @(posedge i_clk) begin
      if (f_out.valid && f_out.ready) begin
         mem_r[c_addr] <= (mem_r[c_addr] & ~c_e0) | (c_d0 & c_e0);
         mem_r[c_addr1] <= (mem_r[c_addr1] & ~c_e1) | (c_d1 & c_e1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wr_stall <= 1'b0;
      end else begin
         o_wr_stall <= !f_in.ready;
      end
   end

   // ==========================================
   // Read port: address on K, words on Cn then C (on Kn then K in single-clock mode)
   logic [SWM_AW-1:0] rd_a_r;
   logic [1:0] rd_ph_r;
   logic [1:0] orise;
   assign orise = single_clk_r ? rise[1:0] : rise[3:2];

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_a_r <= '0;
         rd_ph_r <= 2'h0;
         o_q <= SWM_RST_RDATA;
         o_q_oe <= '0;
      end else begin
         if (rise[0] && !ps_s2_r[1]) begin
            rd_a_r <= addr_s2_r;
            rd_ph_r <= 2'h1;
         end else if (orise[1] && rd_ph_r == 2'h1) begin
            o_q <= mem_r[rd_a_r];
            o_q_oe <= '1;
            rd_ph_r <= 2'h2;
         end else if (orise[0] && rd_ph_r == 2'h2) begin
            o_q <= mem_r[rd_a_r + 1'b1];
            rd_ph_r <= 2'h3;
         end else if (orise[1] && rd_ph_r == 2'h3) begin
            o_q_oe <= '0;
            rd_ph_r <= 2'h0;
         end
      end
   end

   a_oe_off_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (rd_ph_r == 2'h0) |-> (o_q_oe == '0)) else $error("read outputs on while idle");
   a_oe_in_burst: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (rd_ph_r == 2'h2 || rd_ph_r == 2'h3) |-> (o_q_oe == '1))
      else $error("read outputs off during a burst");
   a_wr_second_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (wr_st_r == SWM_WR_SECOND && rise[1] && f_in.ready) |=> cmd_v_r ##1 !cmd_v_r)
      else $error("burst not queued after second word");
   a_wr_desel_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (wr_st_r == SWM_WR_IDLE && ps_s2_r[0]) |=> (wr_st_r == SWM_WR_IDLE))
      else $error("write started while deselected");
   a_mask_none: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (f_out.valid && f_out.ready && c_e0 == '0)
      |=> ((mem_r[$past(c_addr)] & wr_span) == ($past(mem_r[c_addr]) & wr_span)))
      else $error("unselected first word changed the array");
   a_mask_none_hi: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (f_out.valid && f_out.ready && c_e1 == '0)
      |=> ((mem_r[$past(c_addr1)] & wr_span) == ($past(mem_r[c_addr1]) & wr_span)))
      else $error("unselected second word changed the array");
endmodule

// file: dv/swm_ctrl_model.sv
// Memory controller model: drives clock pair pins, write and read bursts.
// Assumes the cores see pin edges a few i_clk cycles late, 6 cycles a level.
module swm_ctrl_model (
   // Clock
   input wire logic i_clk,
   // Pins towards the cores
   output logic o_k,
   output logic o_k_n,
   output logic o_c,
   output logic o_c_n,
   output logic o_wsel_n,
   output logic o_rsel_n,
   output logic [swm_pkg::SWM_AW-1:0] o_addr,
   output logic [swm_pkg::SWM_DW-1:0] o_d,
   output logic [swm_pkg::SWM_LANES-1:0] o_m_n,
   // Read side of the four cores
   input wire logic [swm_pkg::SWM_DW-1:0] i_q [4],
   input wire logic [swm_pkg::SWM_DW-1:0] i_oe [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   import swm_pkg::*;
   logic [SWM_DW-1:0] q0_r [4];
   logic [SWM_DW-1:0] q1_r [4];
   logic [SWM_DW-1:0] on_r [4];
   logic [SWM_DW-1:0] off_r [4];
   // C pair low at release: normal two-clock mode
   initial begin
      {o_k, o_k_n, o_c, o_c_n} = 4'h0;
      {o_wsel_n, o_rsel_n} = 2'h3;
      o_addr = 4'h0;
      o_d = 36'h0;
      o_m_n = 4'hf;
   end
   task automatic step();
      repeat (6) @(posedge i_clk);
   endtask
   // Word0 at K rise, address and word1 at Kn rise, own mask each
   task automatic wr(input logic [3:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
      o_wsel_n <= 1'b0;
      o_d <= d0;
      o_m_n <= m0;
      o_k <= 1'b1;
      step();
      o_k <= 1'b0;
      step();
      o_addr <= a;
      o_d <= d1;
      o_m_n <= m1;
      o_k_n <= 1'b1;
      o_wsel_n <= 1'b1;
      step();
      // Released data shows the inverse, clock parks low between bursts
      o_k_n <= 1'b0;
      o_d <= ~d1;
      o_m_n <= ~m1;
      step();
   endtask
   // Output-clock edge: K pair in single-clock mode, C pair otherwise
   task automatic oclk(input bit sc, input bit neg, input logic v);
      if (sc && neg) begin
         o_k_n <= v;
      end else if (sc) begin
         o_k <= v;
      end else if (neg) begin
         o_c_n <= v;
      end else begin
         o_c <= v;
      end
   endtask
   // Strap for single-clock mode, taken at the next reset release
   task automatic park_c();
      o_c <= 1'b1;
      o_c_n <= 1'b1;
   endtask
   task automatic rd(input logic [3:0] a, input bit sc);
      o_rsel_n <= 1'b0;
      o_addr <= a;
      o_k <= 1'b1;
      step();
      o_k <= 1'b0;
      o_rsel_n <= 1'b1;
      o_addr <= ~a;
      step();
      oclk(sc, 1'b1, 1'b1);
      step();
      q0_r = i_q;
      on_r = i_oe;
      oclk(sc, 1'b1, 1'b0);
      step();
      oclk(sc, 1'b0, 1'b1);
      step();
      q1_r = i_q;
      oclk(sc, 1'b0, 1'b0);
      step();
      oclk(sc, 1'b1, 1'b1);
      step();
      off_r = i_oe;
      oclk(sc, 1'b1, 1'b0);
      step();
   endtask
endmodule

// file: dv/tb_top.sv
// Testbench: four cores, one per width, share the pins of one controller.
// Assumes the core commits a burst within 12 cycles of the Kn rise.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import swm_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic k, k_n, c, c_n, ws_n, rs_n;
   logic [SWM_AW-1:0] addr;
   logic [SWM_DW-1:0] d;
   logic [SWM_LANES-1:0] m_n;
   logic [SWM_DW-1:0] q [4];
   logic [SWM_DW-1:0] oe [4];
   logic stall [4];
   logic [SWM_DW-1:0] exp_mem [4][SWM_DEPTH];
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #2.5 i_clk = ~i_clk;
   swm_ctrl_model i_swm_ctrl_model (.i_clk(i_clk), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n),
      .o_wsel_n(ws_n), .o_rsel_n(rs_n), .o_addr(addr), .o_d(d), .o_m_n(m_n), .i_q(q), .i_oe(oe));
   for (genvar g = 0; g < 4; g++) begin : g_core
      swm_core #(.CFG(swm_cfg_t'(g))) i_swm_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_k(k),
         .i_k_n(k_n), .i_c(c), .i_c_n(c_n), .i_write_port_select_n(ws_n),
         .i_read_port_select_n(rs_n), .i_addr(addr), .i_d(d), .i_lane_write_mask_n(m_n),
         .o_q(q[g]), .o_q_oe(oe[g]), .o_wr_stall(stall[g]));
   end
   function automatic logic [35:0] wm(input int i);
      return (i == 0) ? 36'hff : (i == 1) ? 36'h1ff : (i == 2) ? 36'h3ffff : 36'hfffffffff;
   endfunction
   // Bits written for a mask, per width
   function automatic logic [35:0] lanes(input int i, input logic [3:0] m);
      case (i)
         0: return {28'h0, {4{~m[1]}}, {4{~m[0]}}};
         1: return {27'h0, {9{~m[0]}}};
         2: return {18'h0, {9{~m[1]}}, {9{~m[0]}}};
         default: return {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
      endcase
   endfunction
   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_wr(input logic [3:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
      logic [35:0] l;
      i_swm_ctrl_model.wr(a, d0, d1, m0, m1);
      for (int i = 0; i < 4; i++) begin
         l = lanes(i, m0);
         exp_mem[i][a] = (exp_mem[i][a] & ~l) | (d0 & l);
         l = lanes(i, m1);
         exp_mem[i][4'(a + 1)] = (exp_mem[i][4'(a + 1)] & ~l) | (d1 & l);
      end
   endtask
   task automatic do_rd(input logic [3:0] a, input bit sc);
      i_swm_ctrl_model.rd(a, sc);
      for (int i = 0; i < 4; i++) begin
         chk(i_swm_ctrl_model.q0_r[i] & wm(i), exp_mem[i][a] & wm(i));
         chk(i_swm_ctrl_model.q1_r[i] & wm(i), exp_mem[i][4'(a + 1)] & wm(i));
         chk(i_swm_ctrl_model.on_r[i] & wm(i), wm(i));
         chk(i_swm_ctrl_model.off_r[i] & wm(i), 36'h0);
      end
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         chk(oe[i], 36'h0);
         chk({35'h0, stall[i]}, 36'h0);
      end
      $display("test reset done");
   endtask
   task automatic t_full();
      do_wr(4'h0, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
      do_wr(4'h2, 36'hfedcba987, 36'h55aa55aa5, 4'h0, 4'h0);
      do_wr(4'hf, 36'h0f0f0f0f0, 36'ha5a5a5a5a, 4'h0, 4'h0);
      do_rd(4'h0, 1'b0);
      do_rd(4'h2, 1'b0);
      do_rd(4'hf, 1'b0);
      $display("test full write done");
   endtask
   // Each mask pattern on word0, its inverse on word1
   task automatic t_lanes();
      logic [3:0] pat [4] = '{4'he, 4'hd, 4'hb, 4'h7};
      for (int p = 0; p < 4; p++) begin
         do_wr(4'h0, 36'h3c3c3c3c3 + p, 36'hc3c3c3c3c - p, pat[p], ~pat[p]);
         do_rd(4'h0, 1'b0);
      end
      $display("test lanes done");
   endtask
   task automatic t_none();
      do_wr(4'h2, 36'h000000000, 36'h111111111, 4'hf, 4'h0);
      do_wr(4'h2, 36'h222222222, 36'h333333333, 4'h0, 4'hf);
      do_rd(4'h2, 1'b0);
      $display("test no write done");
   endtask
   // Mid-run reset with the C pair strapped high: K pair times the reads
   task automatic t_single();
      i_swm_ctrl_model.park_c();
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (6) @(posedge i_clk);
      t_reset();
      do_rd(4'h2, 1'b1);
      do_wr(4'h0, 36'h876543210, 36'h13579bdf0, 4'ha, 4'h5);
      do_rd(4'h0, 1'b1);
      $display("test single clock done");
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (6) @(posedge i_clk);
      t_reset();
      t_full();
      t_lanes();
      t_none();
      t_single();
      finish_test();
   end
endmodule
